// ===== design/pwmou_pkg.sv
package pwmou_pkg;
   // Register bus geometry
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 8;

   // Register offsets
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_PRESC = 4'h1;
   localparam logic [3:0] OFS_HIGH = 4'h2;
   localparam logic [3:0] OFS_PDATA = 4'h3;
   localparam logic [3:0] OFS_PDIR = 4'h4;
   localparam logic [3:0] OFS_STAT = 4'h5;

   // Field positions
   localparam int unsigned CTRL_EN_BIT = 0;
   localparam int unsigned CTRL_SRC_BIT = 1;
   localparam int unsigned PORT_BIT = 4;
   localparam int unsigned STAT_RUN_BIT = 0;
   localparam int unsigned STAT_INIT_BIT = 1;
   localparam int unsigned STAT_PIN_BIT = 2;

   // Reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] PRESC_RST = 8'h00;
   localparam logic [7:0] HIGH_RST = 8'h00;
   localparam logic [7:0] PDATA_RST = 8'h00;
   localparam logic [7:0] PDIR_RST = 8'h00;

   // Timing: last tick index of a 255-tick period
   localparam logic [7:0] PERIOD_LAST = 8'hFE;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_INIT_LOW,
      ST_RUN
   } pwmou_state_type;
endpackage

// ===== design/pwmou_prescaler.sv
`timescale 1ns/1ps
module pwmou_prescaler #(
   parameter int unsigned DIV_W = 8
) (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic clr_i,
   input wire logic src_en_i,
   input wire logic [DIV_W-1:0] div_i,
   output logic tick_o
);
   logic [DIV_W-1:0] cnt_q;
   logic [DIV_W-1:0] cnt_d;

   generate
      if (DIV_W < 1) begin : g_bad_width
         $error("pwmou_prescaler: DIV_W must be at least 1");
      end
   endgenerate

   // Divide source enables by div plus one
   always_comb begin
      cnt_d = cnt_q;
      tick_o = 1'b0;
      if (clr_i) begin
         cnt_d = '0;
      end else if (src_en_i) begin
         if (cnt_q >= div_i) begin
            cnt_d = '0;
            tick_o = 1'b1;
         end else begin
            cnt_d = cnt_q + 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule // pwmou_prescaler

// ===== design/pwmou_top.sv
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module pwmou_top (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic [pwmou_pkg::ADDR_W-1:0] reg_addr_i,
   input wire logic [pwmou_pkg::DATA_W-1:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [pwmou_pkg::DATA_W-1:0] reg_rdata_o,
   input wire logic shared_modulator_pin_i,
   output logic shared_modulator_pin_o,
   output logic shared_modulator_pin_oe_o
);
   // Software-visible registers
   logic [7:0] ctrl_q, ctrl_d;
   logic [7:0] pre_presc_q, pre_presc_d;
   logic [7:0] pre_high_q, pre_high_d;
   logic [7:0] port_four_q, port_four_d;
   logic [7:0] port_four_dir_q, port_four_dir_d;
   logic [7:0] rdata_q, rdata_d;
   // Modulator state
   pwmou_pkg::pwmou_state_type state_q, state_d;
   logic [7:0] work_high_q, work_high_d;
   logic [7:0] work_presc_q, work_presc_d;
   logic [7:0] tick_cnt_q, tick_cnt_d;
   logic src_tog_q, src_tog_d;
   logic pin_q, pin_d;
   logic pin_oe_q, pin_oe_d;
   // Pin input synchroniser
   logic [2:0] pin_sync_q;
   logic pin_filt_q, pin_filt_d;
   // Combinational helpers
   logic enable;
   logic src_sel;
   logic src_en;
   logic presc_clr;
   logic tick;
   logic period_end;
   logic pwm_level;
   logic wr_high;

   assign enable = ctrl_q[pwmou_pkg::CTRL_EN_BIT];
   assign src_sel = ctrl_q[pwmou_pkg::CTRL_SRC_BIT];
   assign wr_high = reg_wr_i && (reg_addr_i == pwmou_pkg::OFS_HIGH);

   // Register writes
   always_comb begin
      ctrl_d = ctrl_q;
      pre_presc_d = pre_presc_q;
      pre_high_d = pre_high_q;
      port_four_d = port_four_q;
      port_four_dir_d = port_four_dir_q;
      if (reg_wr_i) begin
         case (reg_addr_i)
            pwmou_pkg::OFS_CTRL: ctrl_d = reg_wdata_i;
            pwmou_pkg::OFS_PRESC: pre_presc_d = reg_wdata_i;
            pwmou_pkg::OFS_HIGH: pre_high_d = reg_wdata_i;
            pwmou_pkg::OFS_PDATA: port_four_d = reg_wdata_i;
            pwmou_pkg::OFS_PDIR: port_four_dir_d = reg_wdata_i;
            default: ctrl_d = ctrl_q;
         endcase
      end
   end

   // Read data valid only in the cycle after the strobe
   always_comb begin
      rdata_d = 8'h00;
      if (reg_rd_i) begin
         case (reg_addr_i)
            pwmou_pkg::OFS_CTRL: rdata_d = ctrl_q;
            pwmou_pkg::OFS_PRESC: rdata_d = pre_presc_q;
            pwmou_pkg::OFS_HIGH: rdata_d = work_high_q;
            pwmou_pkg::OFS_PDATA: rdata_d = port_four_q;
            pwmou_pkg::OFS_PDIR: rdata_d = port_four_dir_q;
            pwmou_pkg::OFS_STAT: begin
               rdata_d[pwmou_pkg::STAT_RUN_BIT] = (state_q == pwmou_pkg::ST_RUN);
               rdata_d[pwmou_pkg::STAT_INIT_BIT] =
                  (state_q == pwmou_pkg::ST_INIT_LOW);
               rdata_d[pwmou_pkg::STAT_PIN_BIT] = pin_filt_q;
            end
            default: rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_q <= pwmou_pkg::CTRL_RST;
         pre_presc_q <= pwmou_pkg::PRESC_RST;
         pre_high_q <= pwmou_pkg::HIGH_RST;
         port_four_q <= pwmou_pkg::PDATA_RST;
         port_four_dir_q <= pwmou_pkg::PDIR_RST;
         rdata_q <= 8'h00;
      end else begin
         ctrl_q <= ctrl_d;
         pre_presc_q <= pre_presc_d;
         pre_high_q <= pre_high_d;
         port_four_q <= port_four_d;
         port_four_dir_q <= port_four_dir_d;
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata_o = rdata_q;

   // Count source: every cycle, or every second cycle when select is set
   assign src_en = src_sel ? src_tog_q : 1'b1;
   assign presc_clr = (state_q == pwmou_pkg::ST_IDLE);

   pwmou_prescaler #(
      .DIV_W(8)
   ) u_presc (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .clr_i(presc_clr),
      .src_en_i(src_en),
      .div_i(work_presc_q),
      .tick_o(tick)
   );

   assign period_end = (state_q == pwmou_pkg::ST_RUN) && tick &&
                       (tick_cnt_q == pwmou_pkg::PERIOD_LAST);

   // High while tick index is below the working value
   assign pwm_level = (state_q == pwmou_pkg::ST_RUN) &&
                      (tick_cnt_q < work_high_q);

   // Modulator sequencing
   always_comb begin
      state_d = state_q;
      work_high_d = work_high_q;
      work_presc_d = work_presc_q;
      tick_cnt_d = tick_cnt_q;
      src_tog_d = ~src_tog_q;
      case (state_q)
         pwmou_pkg::ST_IDLE: begin
            src_tog_d = 1'b0;
            tick_cnt_d = 8'h00;
            work_high_d = pre_high_q;
            work_presc_d = pre_presc_q;
            if (enable) begin
               state_d = pwmou_pkg::ST_INIT_LOW;
            end
         end
         pwmou_pkg::ST_INIT_LOW: begin
            if (!enable) begin
               state_d = pwmou_pkg::ST_IDLE;
            end else if (tick) begin
               state_d = pwmou_pkg::ST_RUN;
               tick_cnt_d = 8'h00;
               work_high_d = pre_high_q;
               work_presc_d = pre_presc_q;
            end
         end
         pwmou_pkg::ST_RUN: begin
            if (!enable) begin
               state_d = pwmou_pkg::ST_IDLE;
            end else if (period_end) begin
               tick_cnt_d = 8'h00;
               work_high_d = pre_high_q;
               work_presc_d = pre_presc_q;
            end else if (tick) begin
               tick_cnt_d = tick_cnt_q + 8'h01;
            end
         end
         default: state_d = pwmou_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_q <= pwmou_pkg::ST_IDLE;
         work_high_q <= pwmou_pkg::HIGH_RST;
         work_presc_q <= pwmou_pkg::PRESC_RST;
         tick_cnt_q <= 8'h00;
         src_tog_q <= 1'b0;
      end else begin
         state_q <= state_d;
         work_high_q <= work_high_d;
         work_presc_q <= work_presc_d;
         tick_cnt_q <= tick_cnt_d;
         src_tog_q <= src_tog_d;
      end
   end

   // Pin mux between modulator and port bit
   always_comb begin
      if (enable) begin
         pin_d = pwm_level;
         pin_oe_d = 1'b1;
      end else begin
         pin_d = port_four_q[pwmou_pkg::PORT_BIT];
         pin_oe_d = port_four_dir_q[pwmou_pkg::PORT_BIT];
      end
   end

   // Pin input filter: accept when second and third stages agree
   always_comb begin
      pin_filt_d = pin_filt_q;
      if (pin_sync_q[1] == pin_sync_q[2]) begin
         pin_filt_d = pin_sync_q[2];
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pin_q <= 1'b0;
         pin_oe_q <= 1'b0;
         pin_sync_q <= 3'h0;
         pin_filt_q <= 1'b0;
      end else begin
         pin_q <= pin_d;
         pin_oe_q <= pin_oe_d;
         pin_sync_q <= {pin_sync_q[1:0], shared_modulator_pin_i};
         pin_filt_q <= pin_filt_d;
      end
   end

   assign shared_modulator_pin_o = pin_q;
   assign shared_modulator_pin_oe_o = pin_oe_q;

   // Cycles spent in the initial low interval, for checking only
   logic [9:0] init_cyc_q;
   logic [9:0] init_expect;

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         init_cyc_q <= 10'h000;
      end else if (state_q == pwmou_pkg::ST_INIT_LOW) begin
         init_cyc_q <= init_cyc_q + 10'h001;
      end else begin
         init_cyc_q <= 10'h000;
      end
   end

   assign init_expect = src_sel ? ({2'b00, work_presc_q} + 10'h001) << 1 :
                                  {2'b00, work_presc_q} + 10'h001;

   a_pin_drives_pwm: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      enable |=> shared_modulator_pin_oe_o == 1'b1)
      else $error("pin not driven while modulator enabled");

   a_pin_port_mode: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      !enable |=> (shared_modulator_pin_oe_o ==
                   $past(port_four_dir_q[pwmou_pkg::PORT_BIT])) &&
                  (shared_modulator_pin_o ==
                   $past(port_four_q[pwmou_pkg::PORT_BIT])))
      else $error("pin does not follow port bit while disabled");

   a_init_low_level: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (state_q == pwmou_pkg::ST_INIT_LOW) && enable |=>
         !shared_modulator_pin_o)
      else $error("pin not low during initial interval");

   a_init_length: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (state_q == pwmou_pkg::ST_INIT_LOW) && enable && tick |->
         (init_cyc_q + 10'h001) == init_expect)
      else $error("initial low interval has wrong length");

   a_period_high_first: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (state_q == pwmou_pkg::ST_RUN) && enable &&
      (tick_cnt_q == 8'h00) && (work_high_q != 8'h00) |=>
         shared_modulator_pin_o)
      else $error("period does not begin high");

   a_high_width: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (state_q == pwmou_pkg::ST_RUN) && enable &&
      (tick_cnt_q >= work_high_q) |=> !shared_modulator_pin_o)
      else $error("pin high past the high-time setting");

   a_prelatch_write: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      wr_high |=> pre_high_q == $past(reg_wdata_i))
      else $error("pre-latch did not take written value");

   a_latch_holds: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (state_q == pwmou_pkg::ST_RUN) && enable && !period_end |=>
         $stable(work_high_q) && $stable(work_presc_q))
      else $error("working latch changed mid-period");

   a_read_latch: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      reg_rd_i && (reg_addr_i == pwmou_pkg::OFS_HIGH) |=>
         reg_rdata_o == $past(work_high_q))
      else $error("high-time read not from working latch");

   a_tick_range: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (state_q == pwmou_pkg::ST_RUN) |->
         tick_cnt_q <= pwmou_pkg::PERIOD_LAST)
      else $error("tick index beyond period end");
endmodule // pwmou_top

// ===== bench/pwmou_load.sv
`timescale 1ns/1ps
// External load: unfiltered driver output with a pull-down, plus pulse meter
module pwmou_load (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic pin_o_i,
   input wire logic pin_oe_i,
   output logic level_o,
   output int hi_w_o,
   output int per_w_o,
   output int rises_o
);
   logic prev_q;
   int hi_q;
   int since_q;

   // Released pin falls to the pull-down level
   assign level_o = pin_oe_i ? pin_o_i : 1'b0;

   // High width at each fall, rise-to-rise period at each rise
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         prev_q <= 1'b0;
         hi_q <= 0;
         since_q <= 0;
         hi_w_o <= 0;
         per_w_o <= 0;
         rises_o <= 0;
      end else begin
         prev_q <= level_o;
         since_q <= since_q + 1;
         hi_q <= level_o ? hi_q + 1 : 0;
         if (level_o && !prev_q) begin
            per_w_o <= since_q;
            since_q <= 1;
            hi_q <= 1;
            rises_o <= rises_o + 1;
         end
         if (!level_o && prev_q) begin
            hi_w_o <= hi_q;
         end
      end
   end
endmodule // pwmou_load

// ===== bench/test_pwm_output_unit.sv
`timescale 1ns/1ps
module test_pwm_output_unit;
   typedef struct {int n; int sel; int h; int hi; int per;} pwmou_row_type;
   logic sys_clk_i;
   logic rst_b_i;
   logic [3:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   logic pin_in;
   logic pin_o;
   logic pin_oe;
   logic [7:0] d;
   int hi_w;
   int per_w;
   int rises;
   int err_count;
   int total_checks;
   int cnt;
   int r0;
   pwmou_row_type rows [5] = '{'{0, 0, 1, 1, 255}, '{2, 0, 3, 9, 765},
      '{1, 1, 2, 8, 1020}, '{0, 1, 100, 200, 510}, '{3, 0, 254, 1016, 1020}};

   pwmou_top i_pwmou_top (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .shared_modulator_pin_i(pin_in),
      .shared_modulator_pin_o(pin_o), .shared_modulator_pin_oe_o(pin_oe));
   pwmou_load i_pwmou_load (.clk_i(sys_clk_i), .rst_b_i(rst_b_i),
      .pin_o_i(pin_o), .pin_oe_i(pin_oe), .level_o(pin_in), .hi_w_o(hi_w),
      .per_w_o(per_w), .rises_o(rises));

   // 250 MHz clock
   initial begin
      sys_clk_i = 1'b0;
      forever #2 sys_clk_i = ~sys_clk_i;
   end

   // Report counts and verdict, then stop
   task automatic wrap_up();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
      end
   endtask

   // One-cycle write and read strobes
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
      @(posedge sys_clk_i);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge sys_clk_i);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
      @(posedge sys_clk_i);
      rd <= 1'b1;
      addr <= a;
      @(posedge sys_clk_i);
      rd <= 1'b0;
      #1 v = rdata;
   endtask

   // Bounded wait for a count of pulse rises at the load
   task automatic wait_rises(input int k);
      int b;
      b = 0;
      while (rises < k && b < 5000) begin
         @(posedge sys_clk_i);
         b++;
      end
      if (rises < k) begin
         err_count++;
         $display("[FAIL] %0t timeout waiting for pulse", $time);
         wrap_up();
      end
   endtask

   // Program, enable, then time initial low, high part and period
   task automatic run_row(input pwmou_row_type r);
      int l;
      l = r.per / 255;
      wr_reg(pwmou_pkg::OFS_CTRL, 8'h00);
      wr_reg(pwmou_pkg::OFS_PRESC, 8'(r.n));
      wr_reg(pwmou_pkg::OFS_HIGH, 8'(r.h));
      wr_reg(pwmou_pkg::OFS_CTRL, 8'(1 + 2 * r.sel));
      cnt = 0;
      do begin
         @(posedge sys_clk_i);
         #1 cnt++;
      end while (pin_o !== 1'b1 && cnt < 3000);
      if (cnt >= 3000) begin
         err_count++;
         $display("[FAIL] %0t timeout waiting for first period", $time);
         wrap_up();
      end
      // Two register stages plus the initial low interval
      chk(16'(cnt), 16'(2 + l));
      chk(16'(pin_oe), 16'h1);
      r0 = rises;
      wait_rises(r0 + 2);
      chk(16'(hi_w), 16'(r.hi));
      chk(16'(per_w), 16'(r.per));
   endtask

   initial begin
      err_count = 0;
      total_checks = 0;
      rst_b_i = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 4'h0;
      wdata = 8'h00;
      repeat (10) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      foreach (rows[i]) begin
         run_row(rows[i]);
      end
      // High-time change inside a running high part
      wr_reg(pwmou_pkg::OFS_CTRL, 8'h00);
      wr_reg(pwmou_pkg::OFS_PRESC, 8'h00);
      wr_reg(pwmou_pkg::OFS_HIGH, 8'h14);
      wr_reg(pwmou_pkg::OFS_CTRL, 8'h01);
      wait_rises(rises + 1);
      r0 = rises;
      wr_reg(pwmou_pkg::OFS_HIGH, 8'h28);
      rd_reg(pwmou_pkg::OFS_HIGH, d);
      chk(16'(d), 16'h0014);
      rd_reg(pwmou_pkg::OFS_STAT, d);
      chk(16'(d), 16'h0005);
      @(posedge sys_clk_i);
      #1 chk(16'(rdata), 16'h0000);
      wait_rises(r0 + 1);
      chk(16'(hi_w), 16'd20);
      wait_rises(r0 + 2);
      chk(16'(hi_w), 16'd40);
      rd_reg(pwmou_pkg::OFS_HIGH, d);
      chk(16'(d), 16'h0028);
      // Port mode drives the fixed level
      wr_reg(pwmou_pkg::OFS_CTRL, 8'h00);
      wr_reg(pwmou_pkg::OFS_PDATA, 8'h10);
      wr_reg(pwmou_pkg::OFS_PDIR, 8'h10);
      repeat (8) @(posedge sys_clk_i);
      #1 chk(16'({pin_oe, pin_o}), 16'h3);
      rd_reg(pwmou_pkg::OFS_STAT, d);
      chk(16'(d), 16'h0004);
      wr_reg(pwmou_pkg::OFS_PDATA, 8'h00);
      repeat (2) @(posedge sys_clk_i);
      #1 chk(16'({pin_oe, pin_o}), 16'h2);
      // Unmapped place ignores writes and reads zero
      wr_reg(4'hF, 8'hA5);
      rd_reg(4'hF, d);
      chk(16'(d), 16'h0000);
      // Prescaler read returns the pre-latch while idle
      wr_reg(pwmou_pkg::OFS_PRESC, 8'h37);
      rd_reg(pwmou_pkg::OFS_PRESC, d);
      chk(16'(d), 16'h0037);
      // Reset in the initial low interval clears pin and registers
      wr_reg(pwmou_pkg::OFS_CTRL, 8'h01);
      repeat (20) @(posedge sys_clk_i);
      rst_b_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      #1 chk(16'({pin_oe, pin_o}), 16'h0);
      @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      for (int a = 0; a < 6; a++) begin
         rd_reg(4'(a), d);
         chk(16'(d), 16'h0000);
      end
      wrap_up();
   end
endmodule // test_pwm_output_unit
